// >>> rtl/tws_dev_end.sv
// Two-wire configuration slave: the device end with its sixteen-byte register file.
`timescale 1ns/10ps
`default_nettype none
`include "tws_regs.svh"
module tws_dev_end (
  // System clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Two-wire link; the serial clock clocks the link-facing logic except the start and stop detectors, which the data line clocks.
  tws_link_if.dev link,
  // Address select straps, pulled up outside the block.
  input wire logic addr_select_hi_pin,
  input wire logic addr_select_mid_pin,
  input wire logic addr_select_lo_pin,
  // Register contents and write notice.
  output logic [8*`TWS_REG_COUNT-1:0] cfg_regs,
  output logic cfg_write_pulse,
  output logic [3:0] cfg_write_index
);

  // System-domain state.
  logic [7:0] reg_mem [0:`TWS_REG_COUNT-1];
  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic [2:0] strap_s3;
  logic [2:0] strap_val;
  logic [6:0] addr_mine;
  logic [2:0] msg_sync;
  logic msg_seen;
  logic msg_new;
  logic [7:0] rd_ptr;
  logic [7:0] rd_byte;

  // Link-domain state.
  tws_pkg::tws_dev_state_e state;
  logic [3:0] bit_cnt;
  logic [6:0] rx;
  logic [7:0] next_byte;
  logic [7:0] ptr;
  logic [7:0] tx;
  logic ack_due;
  logic start_tog;
  logic stop_tog;
  logic start_seen;
  logic stop_seen;
  logic start_pend;
  logic stop_pend;
  logic msg_tog;
  logic msg_we;
  logic [7:0] msg_ptr;
  logic [7:0] msg_data;

  genvar gi;
  generate
    for (gi = 0; gi < `TWS_REG_COUNT; gi = gi + 1) begin : g_flat
      assign cfg_regs[8*gi +: 8] = reg_mem[gi];
    end
  endgenerate

  // Strap pins are asynchronous; a new level counts once two stages agree.
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_s1 <= `TWS_STRAP_RESET;
      strap_s2 <= `TWS_STRAP_RESET;
      strap_s3 <= `TWS_STRAP_RESET;
      strap_val <= `TWS_STRAP_RESET;
    end else begin
      strap_s1 <= {addr_select_hi_pin, addr_select_mid_pin, addr_select_lo_pin};
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      if (strap_s2 == strap_s3) begin
        strap_val <= strap_s3;
      end
    end
  end

  // The slave address is held quasi-static for the link domain.
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_mine <= `TWS_ADDR_DEFAULT;
    end else begin
      addr_mine <= {`TWS_ADDR_FIXED, strap_val[2], ~strap_val[1], ~strap_val[0]};
    end
  end

  // The link clock stands still outside frames, so link flops reset without it.
  always_ff @(negedge link.sda or posedge reset) begin
    if (reset) begin
      start_tog <= 1'b0;
    end else if (link.scl) begin
      start_tog <= ~start_tog;
    end
  end

  always_ff @(posedge link.sda or posedge reset) begin
    if (reset) begin
      stop_tog <= 1'b0;
    end else if (link.scl) begin
      stop_tog <= ~stop_tog;
    end
  end

  // Condition toggles settle long before the next clock rise, so no stages are added.
  assign start_pend = start_tog ^ start_seen;
  assign stop_pend = stop_tog ^ stop_seen;
  assign next_byte = {rx, link.sda};

  // Receive path: sample on the rising serial clock.
  always_ff @(posedge link.scl or posedge reset) begin
    if (reset) begin
      state <= tws_pkg::TWS_DEV_IDLE;
      bit_cnt <= 4'h0;
      rx <= 7'h00;
      ack_due <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
      ptr <= `TWS_PTR_RESET;
      msg_tog <= 1'b0;
      msg_we <= 1'b0;
      msg_ptr <= `TWS_PTR_RESET;
      msg_data <= `TWS_REG_RESET;
    end else begin
      start_seen <= start_tog;
      stop_seen <= stop_tog;
      if (start_pend) begin
        // This rise already carries the first address bit.
        state <= tws_pkg::TWS_DEV_ADDR;
        bit_cnt <= 4'h1;
        rx <= {6'h00, link.sda};
        ack_due <= 1'b0;
      end else if (stop_pend) begin
        state <= tws_pkg::TWS_DEV_IDLE;
        bit_cnt <= 4'h0;
        ack_due <= 1'b0;
      end else if (state != tws_pkg::TWS_DEV_IDLE) begin
        if (bit_cnt == `TWS_ACK_BIT) begin
          bit_cnt <= 4'h0;
          ack_due <= 1'b0;
          // The slot after the read address carries our own acknowledge, not the master's.
          if (state == tws_pkg::TWS_DEV_RDATA && !ack_due) begin
            if (link.sda) begin
              state <= tws_pkg::TWS_DEV_IDLE;
            end else begin
              ptr <= ptr + 8'h01;
              msg_ptr <= ptr + 8'h01;
              msg_we <= 1'b0;
              msg_tog <= ~msg_tog;
            end
          end
        end else begin
          rx <= next_byte[6:0];
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == `TWS_LAST_BIT) begin
            case (state)
              tws_pkg::TWS_DEV_ADDR: begin
                if (next_byte[7:1] == addr_mine) begin
                  ack_due <= 1'b1;
                  if (next_byte[0] == `TWS_DIR_READ) begin
                    state <= tws_pkg::TWS_DEV_RDATA;
                  end else begin
                    state <= tws_pkg::TWS_DEV_REG;
                  end
                end else begin
                  state <= tws_pkg::TWS_DEV_IDLE;
                end
              end
              tws_pkg::TWS_DEV_REG: begin
                ptr <= next_byte;
                msg_ptr <= next_byte;
                msg_we <= 1'b0;
                msg_tog <= ~msg_tog;
                ack_due <= 1'b1;
                state <= tws_pkg::TWS_DEV_WDATA;
              end
              tws_pkg::TWS_DEV_WDATA: begin
                if (tws_pkg::reg_in_range(ptr)) begin
                  msg_ptr <= ptr;
                  msg_data <= next_byte;
                  msg_we <= 1'b1;
                  msg_tog <= ~msg_tog;
                  ptr <= ptr + 8'h01;
                  ack_due <= 1'b1;
                end else begin
                  state <= tws_pkg::TWS_DEV_IDLE;
                end
              end
              default: begin
                ack_due <= 1'b0;
              end
            endcase
          end
        end
      end
    end
  end

  // Transmit path: change the data line only while the serial clock is low.
  always_ff @(negedge link.scl or posedge reset) begin
    if (reset) begin
      link.dev_sda_oe <= 1'b0;
      link.dev_sda_out <= 1'b0;
      tx <= `TWS_REG_RESET;
    end else begin
      link.dev_sda_out <= 1'b0;
      if (bit_cnt == `TWS_ACK_BIT) begin
        link.dev_sda_oe <= ack_due;
      end else if (state == tws_pkg::TWS_DEV_RDATA) begin
        if (bit_cnt == 4'h0) begin
          tx <= rd_byte;
          link.dev_sda_oe <= ~rd_byte[7];
        end else begin
          link.dev_sda_oe <= ~tx[3'h7 - bit_cnt[2:0]];
        end
      end else begin
        link.dev_sda_oe <= 1'b0;
      end
    end
  end

  // The message toggle counts once the second and third stages agree.
  always_ff @(posedge clk) begin
    if (reset) begin
      msg_sync <= 3'h0;
    end else begin
      msg_sync <= {msg_sync[1:0], msg_tog};
    end
  end

  assign msg_new = (msg_sync[2] == msg_sync[1]) && (msg_sync[2] != msg_seen);

  always_ff @(posedge clk) begin
    if (reset) begin
      msg_seen <= 1'b0;
      rd_ptr <= `TWS_PTR_RESET;
      cfg_write_pulse <= 1'b0;
      cfg_write_index <= 4'h0;
    end else begin
      cfg_write_pulse <= 1'b0;
      if (msg_new) begin
        msg_seen <= msg_sync[2];
        if (msg_we) begin
          cfg_write_pulse <= 1'b1;
          cfg_write_index <= msg_ptr[3:0];
          rd_ptr <= msg_ptr + 8'h01;
        end else begin
          rd_ptr <= msg_ptr;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `TWS_REG_COUNT; i++) begin
        reg_mem[i] <= `TWS_REG_RESET;
      end
    end else if (msg_new && msg_we) begin
      reg_mem[msg_ptr[3:0]] <= msg_data;
    end
  end

  // The link side loads this byte at least one high phase after the pointer moves.
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_byte <= `TWS_REG_RESET;
    end else if (tws_pkg::reg_in_range(rd_ptr)) begin
      rd_byte <= reg_mem[rd_ptr[3:0]];
    end else begin
      rd_byte <= `TWS_REG_RESET;
    end
  end

endmodule // tws_dev_end
`default_nettype wire

// >>> rtl/tws_regs.svh
// Constants for the two-wire configuration slave and its bus master.
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
`define TWS_ADDR_FIXED 4'h5
`define TWS_ADDR_DEFAULT 7'h2C
`define TWS_STRAP_RESET 3'h7
`define TWS_REG_COUNT 16
`define TWS_REG_RESET 8'h00
`define TWS_PTR_RESET 8'h00
`define TWS_LAST_BIT 4'h7
`define TWS_ACK_BIT 4'h8
`define TWS_DIR_WRITE 1'b0
`define TWS_DIR_READ 1'b1
`define TWS_CLK_NS 40
`define TWS_QUARTER_NS 650
`define TWS_QUARTER_CYC ((`TWS_QUARTER_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`define TWS_GAP_LAST_PHASE 2'h1
`endif

// >>> rtl/tws_pkg.sv
// Types and shared decoding for the two-wire configuration link.
`include "tws_regs.svh"
package tws_pkg;
  typedef enum logic [2:0] {
    TWS_DEV_IDLE = 3'h0,
    TWS_DEV_ADDR = 3'h1,
    TWS_DEV_REG = 3'h3,
    TWS_DEV_WDATA = 3'h2,
    TWS_DEV_RDATA = 3'h6
  } tws_dev_state_e;

  typedef enum logic [2:0] {
    TWS_HOST_IDLE = 3'h0,
    TWS_HOST_START = 3'h1,
    TWS_HOST_BYTE = 3'h3,
    TWS_HOST_STOP = 3'h2,
    TWS_HOST_GAP = 3'h6
  } tws_host_state_e;

  function automatic logic reg_in_range(input logic [7:0] addr);
    reg_in_range = (addr < 8'(`TWS_REG_COUNT));
  endfunction
endpackage

// >>> rtl/tws_link_if.sv
// Open-drain two-wire link joining the master end and the slave end.
`timescale 1ns/10ps
`default_nettype none
interface tws_link_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Pull-ups hold both wires high unless an enabled driver pulls low.
  assign scl = (host_scl_oe & ~host_scl_out) ? 1'b0 : 1'b1;
  assign sda = ((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out)) ? 1'b0 : 1'b1;

  modport host (
    input scl,
    input sda,
    output host_scl_out,
    output host_scl_oe,
    output host_sda_out,
    output host_sda_oe
  );

  modport dev (
    input scl,
    input sda,
    output dev_sda_out,
    output dev_sda_oe
  );
endinterface
`default_nettype wire

// >>> rtl/tws_host_end.sv
// Two-wire bus master end: single-register write and read transfers.
`timescale 1ns/10ps
`default_nettype none
`include "tws_regs.svh"
module tws_host_end (
  // System clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Two-wire link.
  tws_link_if.host link,
  // Command.
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_dev_addr,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  // Response.
  output logic rsp_valid,
  output logic rsp_nack,
  output logic [7:0] rsp_data
);

  localparam logic [7:0] QUARTER_LAST = 8'(`TWS_QUARTER_CYC - 1);

  tws_pkg::tws_host_state_e st;
  logic [7:0] qcnt;
  logic qtick;
  logic [1:0] ph;
  logic [3:0] bcnt;
  logic [1:0] idx;
  logic [7:0] sh;
  logic rd_mode;
  logic nacked;
  logic rx_byte;
  logic [6:0] dev;
  logic [7:0] regad;
  logic [7:0] wdat;
  logic [2:0] sda_s;
  logic sda_val;

  // Byte order: address+write, register, then data or address+read.
  function automatic logic [7:0] tx_byte(input logic [1:0] i);
    if (i == 2'h0) begin
      tx_byte = {dev, `TWS_DIR_WRITE};
    end else if (i == 2'h1) begin
      tx_byte = regad;
    end else if (rd_mode) begin
      tx_byte = {dev, `TWS_DIR_READ};
    end else begin
      tx_byte = wdat;
    end
  endfunction

  assign rx_byte = rd_mode && (idx == 2'h3);
  assign qtick = (qcnt == QUARTER_LAST);

  // Quarter periods of at least 650 ns give low phases of at least 1.3 us and high phases of at least 650 ns.
  always_ff @(posedge clk) begin
    if (reset || st == tws_pkg::TWS_HOST_IDLE || qtick) begin
      qcnt <= 8'h00;
    end else begin
      qcnt <= qcnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sda_s <= 3'h7;
      sda_val <= 1'b1;
    end else begin
      sda_s <= {sda_s[1:0], link.sda};
      if (sda_s[2] == sda_s[1]) begin
        sda_val <= sda_s[2];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= tws_pkg::TWS_HOST_IDLE;
      ph <= 2'h0;
      bcnt <= 4'h0;
      idx <= 2'h0;
      sh <= 8'h00;
      rd_mode <= 1'b0;
      nacked <= 1'b0;
      dev <= 7'h00;
      regad <= 8'h00;
      wdat <= 8'h00;
      link.host_scl_oe <= 1'b0;
      link.host_scl_out <= 1'b0;
      link.host_sda_oe <= 1'b0;
      link.host_sda_out <= 1'b0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_nack <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      if (st == tws_pkg::TWS_HOST_IDLE) begin
        if (cmd_valid && cmd_ready) begin
          dev <= cmd_dev_addr;
          regad <= cmd_reg;
          wdat <= cmd_wdata;
          rd_mode <= cmd_read;
          cmd_ready <= 1'b0;
          nacked <= 1'b0;
          idx <= 2'h0;
          ph <= 2'h0;
          st <= tws_pkg::TWS_HOST_START;
        end
      end else if (qtick) begin
        ph <= ph + 2'h1;
        case (st)
          tws_pkg::TWS_HOST_START: begin
            if (ph == 2'h0) begin
              link.host_sda_oe <= 1'b0;
            end else if (ph == 2'h1) begin
              link.host_scl_oe <= 1'b0;
            end else if (ph == 2'h2) begin
              link.host_sda_oe <= 1'b1;
            end else begin
              sh <= tx_byte(idx);
              bcnt <= 4'h0;
              st <= tws_pkg::TWS_HOST_BYTE;
            end
          end
          tws_pkg::TWS_HOST_BYTE: begin
            if (ph == 2'h0) begin
              link.host_scl_oe <= 1'b1;
            end else if (ph == 2'h1) begin
              link.host_sda_oe <= (bcnt != `TWS_ACK_BIT) && !rx_byte && !sh[7];
            end else if (ph == 2'h2) begin
              link.host_scl_oe <= 1'b0;
            end else if (bcnt != `TWS_ACK_BIT) begin
              sh <= {sh[6:0], sda_val};
              bcnt <= bcnt + 4'h1;
            end else if (!rx_byte && sda_val) begin
              nacked <= 1'b1;
              st <= tws_pkg::TWS_HOST_STOP;
            end else if (rx_byte || (!rd_mode && idx == 2'h2)) begin
              if (rx_byte) begin
                rsp_data <= sh;
              end
              st <= tws_pkg::TWS_HOST_STOP;
            end else if (rd_mode && idx == 2'h1) begin
              // Take the clock low first so the data line rises only while the clock is low.
              link.host_scl_oe <= 1'b1;
              idx <= 2'h2;
              st <= tws_pkg::TWS_HOST_START;
            end else begin
              idx <= idx + 2'h1;
              sh <= tx_byte(idx + 2'h1);
              bcnt <= 4'h0;
            end
          end
          tws_pkg::TWS_HOST_STOP: begin
            if (ph == 2'h0) begin
              link.host_scl_oe <= 1'b1;
            end else if (ph == 2'h1) begin
              link.host_sda_oe <= 1'b1;
            end else if (ph == 2'h2) begin
              link.host_scl_oe <= 1'b0;
            end else begin
              link.host_sda_oe <= 1'b0;
              st <= tws_pkg::TWS_HOST_GAP;
            end
          end
          default: begin
            if (ph == `TWS_GAP_LAST_PHASE) begin
              ph <= 2'h0;
              st <= tws_pkg::TWS_HOST_IDLE;
              cmd_ready <= 1'b1;
              rsp_valid <= 1'b1;
              rsp_nack <= nacked;
            end
          end
        endcase
      end
    end
  end

endmodule // tws_host_end
`default_nettype wire

// >>> tb/tws_asserts.sv
// Concurrent checks on the two-wire link between the master end and the slave end.
`timescale 1ns/10ps
`default_nettype none
module tws_asserts (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Link wires and slave driver.
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] run_cnt;
  logic [7:0] free_cnt;
  logic [3:0] bit_cnt;
  logic [1:0] byte_cnt;

  // Cycles since the serial clock last changed level, saturating.
  always_ff @(posedge clk) begin
    if (reset || $changed(scl)) begin
      run_cnt <= 8'h01;
    end else if (run_cnt != 8'hFF) begin
      run_cnt <= run_cnt + 8'h01;
    end
  end

  // Cycles since the last stop condition, saturating.
  always_ff @(posedge clk) begin
    if (reset) begin
      free_cnt <= 8'hFF;
    end else if (scl && $rose(sda)) begin
      free_cnt <= 8'h01;
    end else if (free_cnt != 8'hFF) begin
      free_cnt <= free_cnt + 8'h01;
    end
  end

  // Bit and byte position within the frame, restarted by every start.
  always_ff @(posedge clk) begin
    if (reset || (scl && $fell(sda))) begin
      bit_cnt <= 4'h0;
      byte_cnt <= 2'h0;
    end else if ($rose(scl)) begin
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      if (bit_cnt == 4'h8 && byte_cnt != 2'h3) begin
        byte_cnt <= byte_cnt + 2'h1;
      end
    end
  end

  chk_dev_edge_only : assert property (
    scl && $past(scl) |-> $stable(dev_sda_oe)) else $error("slave drive moved while clock high");
  chk_drive_held : assert property (
    $rose(scl) && dev_sda_oe |-> (dev_sda_oe && !sda) [*8]) else $error("slave low not held");
  chk_open_drain : assert property (
    dev_sda_oe |-> !dev_sda_out) else $error("slave drives data high");
  chk_addr_ack_slot : assert property (
    $rose(scl) && byte_cnt == 2'h0 && dev_sda_oe |-> bit_cnt == 4'h8) else $error("address byte driven");
  chk_scl_high_min : assert property (
    $fell(scl) |-> run_cnt >= 8'h0F) else $error("clock high phase short");
  chk_scl_low_min : assert property (
    $rose(scl) |-> run_cnt >= 8'h21) else $error("clock low phase short");
  chk_bus_free : assert property (
    scl && $fell(sda) |-> free_cnt >= 8'h21) else $error("bus free time short");
  chk_start_hold : assert property (
    scl && $fell(sda) |-> scl [*8]) else $error("clock fell too soon after start");
  chk_stop_idle : assert property (
    scl && $rose(sda) |-> (scl && sda && !dev_sda_oe) [*8]) else $error("bus not idle after stop");

  cover property ($rose(scl) && byte_cnt == 2'h0 && bit_cnt == 4'h8 && dev_sda_oe);
  cover property ($rose(scl) && byte_cnt == 2'h0 && bit_cnt == 4'h8 && !dev_sda_oe);
  cover property (scl && $fell(sda) && byte_cnt != 2'h0);
endmodule // tws_asserts
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench joining the master end and the slave end over one link.
`timescale 1ns/10ps
`default_nettype none
`include "tws_regs.svh"
module testbench;
  typedef struct packed {
    logic rd;
    logic [6:0] dev;
    logic [7:0] rg;
    logic [7:0] wd;
    logic nack;
    logic [7:0] rdata;
  } tws_row_s;
  logic clk = 1'b0;
  logic reset;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [6:0] cmd_dev_addr = 7'h00;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [2:0] strap = 3'h7;
  logic cmd_ready;
  logic rsp_valid;
  logic rsp_nack;
  logic [7:0] rsp_data;
  logic [8*`TWS_REG_COUNT-1:0] cfg_regs;
  logic cfg_write_pulse;
  logic [3:0] cfg_write_index;
  int n_mismatch = 0;
  int checked = 0;
  int n_wr = 0;
  tws_row_s rows [11];

  tws_link_if link ();
  tws_dev_end i_tws_dev_end (.clk(clk), .reset(reset), .link(link), .addr_select_hi_pin(strap[2]),
    .addr_select_mid_pin(strap[1]), .addr_select_lo_pin(strap[0]), .cfg_regs(cfg_regs),
    .cfg_write_pulse(cfg_write_pulse), .cfg_write_index(cfg_write_index));
  tws_host_end i_tws_host_end (.clk(clk), .reset(reset), .link(link), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_dev_addr(cmd_dev_addr), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_data(rsp_data));
  tws_asserts i_tws_asserts (.clk(clk), .reset(reset), .scl(link.scl), .sda(link.sda),
    .dev_sda_out(link.dev_sda_out), .dev_sda_oe(link.dev_sda_oe));

  always #20 clk = ~clk;

  always @(posedge clk) begin
    if (cfg_write_pulse === 1'b1) begin
      n_wr <= n_wr + 1;
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Issues one command and waits, bounded, for its response pulse.
  task automatic run(input logic rd, input logic [6:0] dev, input logic [7:0] rg, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_dev_addr <= dev;
    cmd_reg <= rg;
    cmd_wdata <= wd;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      n_mismatch++;
      $display("wrong value at %0t: no response", $time);
      tally_and_finish();
    end
  endtask

  initial begin
    int w0;
    logic [6:0] ea;
    // Reset starts unknown so that the link-side flops see a rising reset edge.
    reset <= 1'b1;
    rows[0] = '{1'b0, 7'h2C, 8'h03, 8'hA5, 1'b0, 8'h00};
    rows[1] = '{1'b1, 7'h2C, 8'h03, 8'h00, 1'b0, 8'hA5};
    rows[2] = '{1'b0, 7'h2C, 8'h0F, 8'h5A, 1'b0, 8'h00};
    rows[3] = '{1'b1, 7'h2C, 8'h0F, 8'h00, 1'b0, 8'h5A};
    rows[4] = '{1'b0, 7'h2C, 8'h00, 8'hFF, 1'b0, 8'h00};
    rows[5] = '{1'b1, 7'h2C, 8'h00, 8'h00, 1'b0, 8'hFF};
    rows[6] = '{1'b0, 7'h2D, 8'h01, 8'h77, 1'b1, 8'h00};
    rows[7] = '{1'b1, 7'h2C, 8'h01, 8'h00, 1'b0, 8'h00};
    rows[8] = '{1'b0, 7'h2C, 8'h10, 8'h33, 1'b1, 8'h00};
    rows[9] = '{1'b1, 7'h2D, 8'h03, 8'h00, 1'b1, 8'h00};
    rows[10] = '{1'b1, 7'h2C, 8'h10, 8'h00, 1'b0, 8'h00};
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    for (int i = 0; i < `TWS_REG_COUNT; i++) begin
      check(cfg_regs[8*i +: 8], `TWS_REG_RESET, "reset reg");
    end
    check({6'h00, link.scl, link.sda}, 8'h03, "idle bus");
    check({7'h00, cmd_ready}, 8'h01, "ready");
    $display("test reset done");
    foreach (rows[i]) begin
      w0 = n_wr;
      run(rows[i].rd, rows[i].dev, rows[i].rg, rows[i].wd);
      check({7'h00, rsp_nack}, {7'h00, rows[i].nack}, "nack");
      check(8'(n_wr - w0), {7'h00, ~rows[i].rd & ~rows[i].nack}, "pulses");
      if (rows[i].rd && !rows[i].nack) begin
        check(rsp_data, rows[i].rdata, "read data");
      end
      if (!rows[i].rd && !rows[i].nack) begin
        check({4'h0, cfg_write_index}, rows[i].rg, "index");
        check(cfg_regs[8*int'(rows[i].rg[3:0]) +: 8], rows[i].wd, "reg");
      end
    end
    $display("test rows done");
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      strap <= 3'(s);
      repeat (8) @(posedge clk);
      ea = {`TWS_ADDR_FIXED, strap[2], ~strap[1], ~strap[0]};
      run(1'b0, ea, 8'h04, {5'h00, strap});
      check({7'h00, rsp_nack}, 8'h00, "strap ack");
      check(cfg_regs[39:32], {5'h00, strap}, "strap reg");
      run(1'b0, ea ^ 7'h01, 8'h04, 8'hEE);
      check({7'h00, rsp_nack}, 8'h01, "strap nack");
      check(cfg_regs[39:32], {5'h00, strap}, "reg kept");
    end
    $display("test straps done");
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
